// >>> design/ivu_interrupt_vectoring_unit.v
/*
  ivu_interrupt_vectoring_unit.v: interrupt vectoring and in-service tracking for an 8-bit core.
  Assumes sources give flags as synchronous levels, the sequencer reports the current pc,
  stack top and return strobes, and performs stack writes/reads requested here.
*/
`default_nettype none
`include "ivu_consts.vh"

module ivu_interrupt_vectoring_unit #(
  parameter NSRC = `IVU_NSRC
) (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // external interrupt pins, active low, and trigger mode (1 = falling edge)
  input wire [5:0] ext_int_n,
  input wire [5:0] ext_edge_mode,
  // timer overflow events, level during the cycle the overflow happens
  input wire timer0_overflow,
  input wire timer1_overflow,
  // flags owned by other peripherals, levels
  input wire serial0_flag,
  input wire serial1_flag,
  input wire timer2_flag,
  input wire watchdog_timeout_flag,
  // software clear of the local flags (ext bits act in edge mode only): bit 0 ext0 ... 5 ext5, 6 timer0, 7 timer1
  input wire [7:0] flag_clear,
  // enables and priority
  input wire global_enable,
  input wire [NSRC-1:0] source_enable,
  input wire [NSRC-1:0] source_high_priority,
  // sequencer
  input wire [15:0] current_pc,
  input wire [15:0] stack_top,
  input wire return_from_interrupt,
  input wire plain_subroutine_return,
  // flags held here, visible to software
  output reg [5:0] ext_flag_reg,
  output reg timer0_overflow_flag_reg,
  output reg timer1_overflow_flag_reg,
  // machine-cycle state, 0 = first state
  output reg [1:0] clock_state_reg,
  // call sequence
  output reg call_busy_reg,
  output reg push_valid_reg,
  output reg [15:0] push_pc_reg,
  output reg pc_load_reg,
  output reg [15:0] pc_value_reg,
  output reg [3:0] active_source_reg,
  // in-service state: bit 0 low level, bit 1 high level
  output reg [1:0] in_service_reg
);

  // ==================================================
  // helpers
  function [15:0] vector_of;
    input [3:0] src;
    begin
      case (src)
        `IVU_SRC_EXT0: vector_of = `IVU_VEC_EXT0;
        `IVU_SRC_T0: vector_of = `IVU_VEC_T0;
        `IVU_SRC_EXT1: vector_of = `IVU_VEC_EXT1;
        `IVU_SRC_T1: vector_of = `IVU_VEC_T1;
        `IVU_SRC_SER0: vector_of = `IVU_VEC_SER0;
        `IVU_SRC_T2: vector_of = `IVU_VEC_T2;
        `IVU_SRC_SER1: vector_of = `IVU_VEC_SER1;
        `IVU_SRC_EXT2: vector_of = `IVU_VEC_EXT2;
        `IVU_SRC_EXT3: vector_of = `IVU_VEC_EXT3;
        `IVU_SRC_EXT4: vector_of = `IVU_VEC_EXT4;
        `IVU_SRC_EXT5: vector_of = `IVU_VEC_EXT5;
        `IVU_SRC_WDT: vector_of = `IVU_VEC_WDT;
        default: vector_of = `IVU_VEC_EXT0;
      endcase
    end
  endfunction

  // ==================================================
  // machine cycle state counter
  wire at_sample = (clock_state_reg == `IVU_STATE_SAMPLE);
  wire at_last = (clock_state_reg == `IVU_STATE_LAST);

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clock_state_reg <= 2'd0;
    end else begin
      clock_state_reg <= clock_state_reg + 2'd1;
    end
  end

  // ==================================================
  // flag capture at the third state
  reg [5:0] ext_level_reg;
  reg t0_event_reg;
  reg t1_event_reg;
  wire [5:0] ext_active = ~ext_int_n;
  wire [5:0] ext_fall = ext_active & ~ext_level_reg;
  reg [5:0] ext_hw_clear;
  reg t0_hw_clear;
  reg t1_hw_clear;
  reg [5:0] ext_next;
  integer k;

  always @* begin
    for (k = 0; k < 6; k = k + 1) begin
      if (ext_edge_mode[k]) begin
        ext_next[k] = ext_flag_reg[k];
        if (ext_hw_clear[k] || flag_clear[k])
          ext_next[k] = 1'b0;
        if (at_sample && ext_fall[k])
          ext_next[k] = 1'b1; // set wins over clear
      end else begin
        // level mode follows the pin sample; calls do not touch it
        ext_next[k] = at_sample ? ext_active[k] : ext_flag_reg[k];
      end
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ext_level_reg <= 6'h00;
      ext_flag_reg <= 6'h00;
      t0_event_reg <= 1'b0;
      t1_event_reg <= 1'b0;
      timer0_overflow_flag_reg <= 1'b0;
      timer1_overflow_flag_reg <= 1'b0;
    end else begin
      if (at_sample)
        ext_level_reg <= ext_active;
      ext_flag_reg <= ext_next;
      // overflow seen anywhere in the cycle is posted at the third state
      t0_event_reg <= at_sample ? 1'b0 : (t0_event_reg | timer0_overflow);
      t1_event_reg <= at_sample ? 1'b0 : (t1_event_reg | timer1_overflow);
      if (at_sample && (t0_event_reg || timer0_overflow))
        timer0_overflow_flag_reg <= 1'b1;
      else if (t0_hw_clear || flag_clear[6])
        timer0_overflow_flag_reg <= 1'b0;
      if (at_sample && (t1_event_reg || timer1_overflow))
        timer1_overflow_flag_reg <= 1'b1;
      else if (t1_hw_clear || flag_clear[7])
        timer1_overflow_flag_reg <= 1'b0;
    end
  end

  // ==================================================
  // polling: snapshot at end of cycle, evaluated in the next one
  wire [NSRC-1:0] live_req = {watchdog_timeout_flag, ext_flag_reg[5:2], serial1_flag, timer2_flag,
    serial0_flag, timer1_overflow_flag_reg, ext_flag_reg[1], timer0_overflow_flag_reg, ext_flag_reg[0]};
  reg [NSRC-1:0] polled_reg;

  always @(posedge clk_sys or posedge rst) begin
    if (rst)
      polled_reg <= {NSRC{1'b0}};
    else if (at_last)
      polled_reg <= live_req;
  end

  // eligibility and fixed-order pick, high level first
  wire [NSRC-1:0] elig = polled_reg & source_enable & {NSRC{global_enable}};
  wire [NSRC-1:0] elig_hi = elig & source_high_priority & {NSRC{~in_service_reg[1]}};
  wire [NSRC-1:0] elig_lo = elig & ~source_high_priority & {NSRC{~(|in_service_reg)}};
  reg [3:0] pick;
  reg pick_hi;
  integer j;

  always @* begin
    pick = `IVU_SRC_NONE;
    pick_hi = 1'b0;
    for (j = NSRC - 1; j >= 0; j = j - 1) begin
      if (elig_lo[j])
        pick = j[3:0];
    end
    for (j = NSRC - 1; j >= 0; j = j - 1) begin
      if (elig_hi[j]) begin
        pick = j[3:0];
        pick_hi = 1'b1;
      end
    end
  end

  // ==================================================
  // call sequencer
  reg [1:0] seq_state_reg;
  reg [2:0] mc_count_reg;
  reg active_hi_reg;
  wire launch = (seq_state_reg == `IVU_ST_IDLE) && at_last && (pick != `IVU_SRC_NONE);
  wire call_done = (seq_state_reg == `IVU_ST_CALL) && at_last && (mc_count_reg == `IVU_CALL_MCS - 3'd1);

  always @* begin
    ext_hw_clear = 6'h00;
    t0_hw_clear = 1'b0;
    t1_hw_clear = 1'b0;
    if (launch) begin
      case (pick)
        `IVU_SRC_EXT0: ext_hw_clear[0] = ext_edge_mode[0];
        `IVU_SRC_EXT1: ext_hw_clear[1] = ext_edge_mode[1];
        `IVU_SRC_T0: t0_hw_clear = 1'b1;
        `IVU_SRC_T1: t1_hw_clear = 1'b1;
        // serial, timer 2, watchdog and ext2..5 flags untouched
        default: t0_hw_clear = 1'b0;
      endcase
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      seq_state_reg <= `IVU_ST_IDLE;
      mc_count_reg <= 3'd0;
      active_hi_reg <= 1'b0;
      call_busy_reg <= 1'b0;
      push_valid_reg <= 1'b0;
      push_pc_reg <= 16'h0000;
      pc_load_reg <= 1'b0;
      pc_value_reg <= 16'h0000;
      active_source_reg <= `IVU_SRC_NONE;
      in_service_reg <= 2'b00;
    end else begin
      push_valid_reg <= 1'b0;
      pc_load_reg <= 1'b0;
      case (seq_state_reg)
        `IVU_ST_IDLE: begin
          if (launch) begin
            seq_state_reg <= `IVU_ST_CALL;
            mc_count_reg <= 3'd0;
            call_busy_reg <= 1'b1;
            active_source_reg <= pick;
            active_hi_reg <= pick_hi;
            push_valid_reg <= 1'b1; // only pc pushed, no status word
            push_pc_reg <= current_pc;
          end
        end
        `IVU_ST_CALL: begin
          if (call_done) begin
            seq_state_reg <= `IVU_ST_IDLE;
            call_busy_reg <= 1'b0;
            pc_load_reg <= 1'b1;
            pc_value_reg <= vector_of(active_source_reg);
            if (active_hi_reg)
              in_service_reg[1] <= 1'b1;
            else
              in_service_reg[0] <= 1'b1;
          end else if (at_last) begin
            mc_count_reg <= mc_count_reg + 3'd1;
          end
        end
        default: seq_state_reg <= `IVU_ST_IDLE;
      endcase
      // returns: pc comes straight from stack, no check of its contents
      if ((return_from_interrupt || plain_subroutine_return) && !call_busy_reg) begin
        pc_load_reg <= 1'b1;
        pc_value_reg <= stack_top;
        if (return_from_interrupt) begin
          if (in_service_reg[1])
            in_service_reg[1] <= 1'b0;
          else
            in_service_reg[0] <= 1'b0;
        end
      end
    end
  end

endmodule // ivu_interrupt_vectoring_unit
`default_nettype wire

// >>> shared/ivu_consts.vh
/*
  ivu_consts.vh: constants of the interrupt vectoring unit (vectors, source indices, state codes, timing).
  Assumes inclusion by bare name from the design file; definitions only.
*/
`ifndef IVU_CONSTS_VH
`define IVU_CONSTS_VH

// ==================================================
// machine cycle
`define IVU_STATES_PER_MC 2'd3
`define IVU_STATE_SAMPLE 2'd2
`define IVU_STATE_LAST 2'd3
`define IVU_CALL_MCS 3'd4

// ==================================================
// source indices, lower index polled first
`define IVU_NSRC 12
`define IVU_SRC_EXT0 4'd0
`define IVU_SRC_T0 4'd1
`define IVU_SRC_EXT1 4'd2
`define IVU_SRC_T1 4'd3
`define IVU_SRC_SER0 4'd4
`define IVU_SRC_T2 4'd5
`define IVU_SRC_SER1 4'd6
`define IVU_SRC_EXT2 4'd7
`define IVU_SRC_EXT3 4'd8
`define IVU_SRC_EXT4 4'd9
`define IVU_SRC_EXT5 4'd10
`define IVU_SRC_WDT 4'd11
`define IVU_SRC_NONE 4'd15

// ==================================================
// vector addresses
`define IVU_VEC_EXT0 16'h0003
`define IVU_VEC_T0 16'h000b
`define IVU_VEC_EXT1 16'h0013
`define IVU_VEC_T1 16'h001b
`define IVU_VEC_SER0 16'h0023
`define IVU_VEC_T2 16'h002b
`define IVU_VEC_SER1 16'h003b
`define IVU_VEC_EXT2 16'h0043
`define IVU_VEC_EXT3 16'h004b
`define IVU_VEC_EXT4 16'h0053
`define IVU_VEC_EXT5 16'h005b
`define IVU_VEC_WDT 16'h0063

// ==================================================
// sequencer states
`define IVU_ST_IDLE 2'd0
`define IVU_ST_CALL 2'd1

`endif

// >>> verif/ivu_props.sv
/* ivu_props.sv: assertions on the vectoring unit ports.
   Assumes it is bound to ivu_interrupt_vectoring_unit with one clock. */
`default_nettype none
// ====
// checker
module ivu_props (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // sequencer side
  input wire logic [15:0] current_pc,
  input wire logic [15:0] stack_top,
  input wire logic return_from_interrupt,
  input wire logic plain_subroutine_return,
  // unit outputs
  input wire logic [1:0] clock_state_reg,
  input wire logic call_busy_reg,
  input wire logic push_valid_reg,
  input wire logic [15:0] push_pc_reg,
  input wire logic pc_load_reg,
  input wire logic [15:0] pc_value_reg,
  input wire logic [3:0] active_source_reg,
  input wire logic [1:0] in_service_reg,
  // timer overflow flags held by the unit
  input wire logic timer0_overflow_flag_reg,
  input wire logic timer1_overflow_flag_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // the table skips one slot after timer 2
  function automatic logic [15:0] vec(input logic [3:0] s);
    return {9'h0, s, 3'h3} + ((s > 4'd5) ? 16'h0008 : 16'h0000);
  endfunction
  sequence call_run;
    call_busy_reg [*8] ##1 call_busy_reg [*8] ##1 (pc_load_reg && !call_busy_reg);
  endsequence
  sequence ret_load;
    pc_load_reg && pc_value_reg == $past(stack_top);
  endsequence
  // the first edge after reset still sees the reset value of the state counter
  state_order_a: assert property (!$past(rst) |-> clock_state_reg == $past(clock_state_reg) + 2'd1)
    else $error("clock state out of order");
  launch_phase_a: assert property ($rose(call_busy_reg) |-> push_valid_reg && $past(clock_state_reg) == 2'd3)
    else $error("call launched off the poll state");
  call_length_a: assert property (push_valid_reg |-> call_run)
    else $error("call length wrong");
  vector_a: assert property ($fell(call_busy_reg) |-> pc_load_reg && pc_value_reg == vec(active_source_reg))
    else $error("wrong vector loaded");
  push_pc_a: assert property (push_valid_reg |-> push_pc_reg == $past(current_pc))
    else $error("pushed pc wrong");
  return_pc_a: assert property ((return_from_interrupt || plain_subroutine_return) && !call_busy_reg |=> ret_load)
    else $error("return did not load popped pc");
  isr_done_a: assert property (return_from_interrupt && !call_busy_reg |=>
    in_service_reg == ($past(in_service_reg) > 2'd1 ? $past(in_service_reg) & 2'h1 : 2'h0))
    else $error("in-service not ended");
  keep_service_a: assert property (plain_subroutine_return && !return_from_interrupt && !call_busy_reg |=>
    $stable(in_service_reg))
    else $error("plain return changed in-service");
  timer_phase_a: assert property ($rose(timer0_overflow_flag_reg) || $rose(timer1_overflow_flag_reg) |->
    $past(clock_state_reg) == 2'd2)
    else $error("timer flag set off the third state");
  timer_clear_a: assert property ($rose(call_busy_reg) |->
    !(active_source_reg == 4'd1 && timer0_overflow_flag_reg) && !(active_source_reg == 4'd3 && timer1_overflow_flag_reg))
    else $error("timer flag not cleared on vectoring");
endmodule // ivu_props
bind ivu_interrupt_vectoring_unit ivu_props u_ivu_props (.clk_sys(clk_sys), .rst(rst), .current_pc(current_pc),
  .stack_top(stack_top), .return_from_interrupt(return_from_interrupt),
  .plain_subroutine_return(plain_subroutine_return), .clock_state_reg(clock_state_reg),
  .call_busy_reg(call_busy_reg), .push_valid_reg(push_valid_reg), .push_pc_reg(push_pc_reg),
  .pc_load_reg(pc_load_reg), .pc_value_reg(pc_value_reg), .active_source_reg(active_source_reg),
  .in_service_reg(in_service_reg), .timer0_overflow_flag_reg(timer0_overflow_flag_reg),
  .timer1_overflow_flag_reg(timer1_overflow_flag_reg));
`default_nettype wire

// >>> verif/ivu_seq_model.sv
/* ivu_seq_model.sv: sequencer model holding the pc and a small stack.
   Assumes pushes and pops come from the unit and the bench. */
`default_nettype none
// ====
// sequencer
module ivu_seq_model #(
  parameter logic [15:0] PC_START = 16'h0100
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // from the unit and the bench
  input wire logic push_valid,
  input wire logic pop,
  input wire logic pc_load,
  input wire logic [15:0] pc_value,
  // to the unit
  output logic [15:0] current_pc,
  output logic [15:0] stack_top
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] stack_reg;
  assign stack_top = stack_reg[15:0];
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stack_reg <= 64'h0;
      current_pc <= PC_START;
    end else begin
      // a pop rotates, so a stack emptied too far shows stale entries
      if (push_valid) stack_reg <= {stack_reg[47:0], current_pc};
      else if (pop) stack_reg <= {stack_reg[15:0], stack_reg[63:16]};
      if (pc_load) current_pc <= pc_value + 16'h0005;
    end
  end
endmodule // ivu_seq_model
`default_nettype wire

// >>> verif/tb.sv
/* tb.sv: self-checking bench for the vectoring unit.
   Assumes the sequencer model and the bound checker. */
`default_nettype none
// ====
// bench
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [11:0] req = 12'h0;
  logic global_enable = 1'b0;
  logic [11:0] source_enable = 12'h0;
  logic [11:0] source_high_priority = 12'h0;
  logic ret_i = 1'b0;
  logic ret_p = 1'b0;
  wire [15:0] cur_pc, stk, push_pc, pc_value;
  wire [5:0] ext_flag;
  wire t0f, t1f, busy, push_valid, pc_load;
  wire [1:0] in_svc;
  logic [15:0] exp_q[$];
  logic [1:0] svc;
  integer seed = 32'he9eb;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  always #5 clk_sys = ~clk_sys;
  ivu_interrupt_vectoring_unit u_ivu_interrupt_vectoring_unit (.clk_sys(clk_sys), .rst(rst),
    .ext_int_n(~{req[10:7], req[2], req[0]}), .ext_edge_mode(6'h01), .timer0_overflow(req[1]),
    .timer1_overflow(req[3]), .serial0_flag(req[4]), .serial1_flag(req[6]), .timer2_flag(req[5]),
    .watchdog_timeout_flag(req[11]), .flag_clear(8'h00), .global_enable(global_enable),
    .source_enable(source_enable), .source_high_priority(source_high_priority), .current_pc(cur_pc),
    .stack_top(stk), .return_from_interrupt(ret_i), .plain_subroutine_return(ret_p), .ext_flag_reg(ext_flag),
    .timer0_overflow_flag_reg(t0f), .timer1_overflow_flag_reg(t1f), .clock_state_reg(), .call_busy_reg(busy),
    .push_valid_reg(push_valid), .push_pc_reg(push_pc), .pc_load_reg(pc_load), .pc_value_reg(pc_value),
    .active_source_reg(), .in_service_reg(in_svc));
  ivu_seq_model u_ivu_seq_model (.clk_sys(clk_sys), .rst(rst), .push_valid(push_valid), .pop(ret_i | ret_p),
    .pc_load(pc_load), .pc_value(pc_value), .current_pc(cur_pc), .stack_top(stk));
  function automatic logic [15:0] vec(input int s);
    return {9'h0, s[3:0], 3'h3} + ((s > 5) ? 16'h0008 : 16'h0000);
  endfunction
  task check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask
  task give_verdict;
    if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task wait_load;
    do @(negedge clk_sys); while (pc_load !== 1'b1);
  endtask
  always @(negedge clk_sys) begin
    if (pc_load === 1'b1) begin
      if (exp_q.size() == 0) check("pc_load", 16'h0, 16'h1);
      else check("pc_value", exp_q.pop_front(), pc_value);
    end
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    global_enable = 1'b1;
    for (int i = 0; i < 12; i++) begin
      @(negedge clk_sys);
      source_enable = 12'h1 << i;
      source_high_priority = 12'($random(seed));
      req = 12'h1 << i;
      exp_q.push_back(vec(i));
      // overflow is an event: drop it after one machine cycle
      if (i == 1 || i == 3) begin
        repeat (4) @(negedge clk_sys);
        req = 12'h0;
      end
      wait_load();
      if (i == 0) check("ext0_flag", 16'h0, ext_flag[0]);
      if (i == 2) check("ext1_flag", 16'h1, ext_flag[1]);
      if (i == 1) check("t0_flag", 16'h0, t0f);
      if (i == 3) check("t1_flag", 16'h0, t1f);
      req = 12'h0;
      repeat (8) @(negedge clk_sys);
      if (i == 4) begin
        svc = in_svc;
        exp_q.push_back(stk);
        ret_p = 1'b1;
        @(negedge clk_sys);
        ret_p = 1'b0;
        repeat (2) @(negedge clk_sys);
        check("svc_plain", svc, in_svc);
      end
      exp_q.push_back(stk);
      ret_i = 1'b1;
      @(negedge clk_sys);
      ret_i = 1'b0;
      repeat (2) @(negedge clk_sys);
      check("svc_return_from_interrupt", 16'h0, in_svc);
    end
    global_enable = 1'b0;
    source_enable = 12'h020;
    req = 12'h020;
    repeat (40) @(negedge clk_sys);
    exp_q.push_back(16'h002b);
    global_enable = 1'b1;
    wait_load();
    req = 12'h0;
    repeat (4) @(negedge clk_sys);
    check("queue_left", 16'h0, exp_q.size());
    give_verdict();
  end
endmodule // tb
`default_nettype wire
